// *** hdl/line_share_pkg.sv ***
// shared constants and types for the serial line share arbiter
package line_share_pkg;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int unsigned CLK_HZ          = 250_000_000;
  localparam int unsigned RTS_DELAY_MS    = 25;
  localparam int unsigned CUTOFF_LONG_S   = 32;
  localparam int unsigned CUTOFF_SHORT_S  = 10;
  // one millisecond tick from the clock divider
  localparam int unsigned MS_TICK_CYCLES  = CLK_HZ / 1000;
  localparam int unsigned CUTOFF_LONG_MS  = CUTOFF_LONG_S * 1000;
  localparam int unsigned CUTOFF_SHORT_MS = CUTOFF_SHORT_S * 1000;

  // ==========================================================================
  // option encodings
  // ==========================================================================
  localparam logic [1:0] CUTOFF_32S  = 2'h0;
  localparam logic [1:0] CUTOFF_10S  = 2'h1;
  localparam logic [1:0] CUTOFF_NONE = 2'h2;
  localparam logic       ACT_TX_ONLY = 1'h0;
  localparam logic       ACT_TX_RX   = 1'h1;
  localparam logic       FANOUT_BCAST = 1'h0;
  localparam logic       POLICY_RR   = 1'h0;
  localparam logic       MARK_LEVEL  = 1'h1;

  // master-side modem control lines as they arrive
  typedef struct packed {
    logic rxd;
    logic cts;
  } master_in_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_DELAY = 3'h2,
    ST_GRANT = 3'h4
  } arb_state_t;

endpackage

// *** hdl/sample_fifo.sv ***
// small valid/ready fifo
`timescale 1ns/1ns
module sample_fifo #(
  parameter int unsigned WIDTH = 2,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (count_ff != (AW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign out_data  = mem[rd_ptr_ff];

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// *** hdl/serial_line_share_arbiter.sv ***
// arbiter sharing one master serial line among several slave ports
// How it works
// - delay option off: request passes straight through
// - delay option on: rise delayed 25 ms
// - broadcast mode: master rxd to all slaves
// - gated mode: only granted port, others mark
// - gated mode: rxd only while slave requests
// - round robin scan starts after released port
// - round robin grants first requester found
// - fixed priority: lowest port index wins
// - two-port build always fixed priority
// - idle requesting slave cut off at timeout
// - per-port interval and activity source
// - first interval setting is 32 seconds
// - second interval setting is 10 seconds
// - third interval setting disables cutoff
// - tx-only: timer runs while no transmit
// - tx-only: clear on drop or transmit
// - tx-rx: timer runs with no traffic
// - tx-rx: clear on drop or traffic
// - activity source ignored when cutoff disabled
// - one grant at a time until release
// - cut-off port skipped until request re-raised
// - master cts only to granted requester
// - detect disable masks the port request
`timescale 1ns/1ns
module serial_line_share_arbiter #(
  parameter int unsigned PORTS        = 4,
  parameter int unsigned MS_TICK      = line_share_pkg::MS_TICK_CYCLES,
  parameter int unsigned DELAY_MS     = line_share_pkg::RTS_DELAY_MS,
  parameter int unsigned LONG_MS      = line_share_pkg::CUTOFF_LONG_MS,
  parameter int unsigned SHORT_MS     = line_share_pkg::CUTOFF_SHORT_MS,
  parameter int unsigned FIFO_DEPTH   = 4
) (
  input  wire logic                 ref_clk,
  input  wire logic                 arst_n,
  input  wire logic                 request_delay_select,
  input  wire logic                 receive_fanout_select,
  input  wire logic                 selection_policy_select,
  input  wire logic [2*PORTS-1:0]   port_cutoff_interval_selects,
  input  wire logic [PORTS-1:0]     port_activity_source_selects,
  input  wire logic [PORTS-1:0]     port_detect_disable,
  input  wire logic [PORTS-1:0]     slave_rts,
  input  wire logic [PORTS-1:0]     slave_txd,
  output logic      [PORTS-1:0]     slave_rxd,
  output logic      [PORTS-1:0]     slave_cts,
  input  wire line_share_pkg::master_in_t master_in,
  output logic                      master_txd,
  output logic                      master_rts,
  output logic      [PORTS-1:0]     grant_onehot,
  output logic      [PORTS-1:0]     cutoff_lock
);
  localparam int unsigned PW = (PORTS > 1) ? $clog2(PORTS) : 1;

  // ==========================================================================
  // master input path through the fifo (always drained, two cycle latency)
  // ==========================================================================
  line_share_pkg::master_in_t mst_q;
  logic                       fifo_in_ready;
  logic                       fifo_out_valid;
  logic [1:0]                 fifo_out_data;

  sample_fifo #(.WIDTH(2), .DEPTH(FIFO_DEPTH)) u_in_fifo (
    .ref_clk   (ref_clk),
    .arst_n    (arst_n),
    .in_data   (master_in),
    .in_valid  (1'b1),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (1'b1)
  );

  logic [1:0] mst_hold_ff;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mst_hold_ff <= {line_share_pkg::MARK_LEVEL, 1'b0};
    end else if (fifo_out_valid) begin
      mst_hold_ff <= fifo_out_data;
    end
  end
  assign mst_q = mst_hold_ff;

  // ==========================================================================
  // millisecond tick
  // ==========================================================================
  logic [31:0] div_ff;
  logic        ms_tick;
  assign ms_tick = (div_ff == MS_TICK - 1);
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_ff <= '0;
    end else begin
      div_ff <= ms_tick ? '0 : div_ff + 32'h1;
    end
  end

  // ==========================================================================
  // request qualification
  // ==========================================================================
  logic [PORTS-1:0] rts_prev_ff;
  logic [PORTS-1:0] lock_ff;
  logic [PORTS-1:0] req_raw;
  logic [PORTS-1:0] req_ok;
  assign req_raw = slave_rts & ~port_detect_disable;
  assign req_ok  = req_raw & ~lock_ff;

  // ==========================================================================
  // selection
  // ==========================================================================
  logic [PW-1:0] last_ff;
  logic [PW-1:0] pick_idx;
  logic          pick_any;
  logic          use_rr;
  // two-port build forced to fixed priority
  assign use_rr = (PORTS > 2) && (selection_policy_select == line_share_pkg::POLICY_RR);

  always_comb begin
    int unsigned k;
    pick_idx = '0;
    pick_any = 1'b0;
    k = 0;
    for (int i = PORTS - 1; i >= 0; i--) begin
      if (!use_rr && req_ok[i]) begin
        pick_idx = PW'(i);
        pick_any = 1'b1;
      end
    end
    // round robin scan from next port
    for (int j = PORTS; j >= 1; j--) begin
      k = (int'(last_ff) + j) % PORTS;
      if (use_rr && req_ok[k]) begin
        pick_idx = PW'(k);
        pick_any = 1'b1;
      end
    end
  end

  // ==========================================================================
  // grant state machine
  // ==========================================================================
  line_share_pkg::arb_state_t state_ff;
  line_share_pkg::arb_state_t nxt_state;
  logic [PW-1:0]              act_ff;
  logic [15:0]                dly_ff;
  logic                       act_req;
  logic                       cutoff_hit;
  logic                       dly_done;

  assign act_req  = req_raw[act_ff];
  // no delay option; rising edge delayed
  assign dly_done = (request_delay_select == 1'b0) ||
                    (ms_tick && dly_ff >= 16'(DELAY_MS - 1));

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      line_share_pkg::ST_IDLE: begin
        if (pick_any) begin
          nxt_state = line_share_pkg::ST_DELAY;
        end
      end
      line_share_pkg::ST_DELAY: begin
        if (!act_req || cutoff_hit) begin
          nxt_state = line_share_pkg::ST_IDLE;
        end else if (dly_done) begin
          nxt_state = line_share_pkg::ST_GRANT;
        end
      end
      line_share_pkg::ST_GRANT: begin
        if (!act_req || cutoff_hit) begin
          nxt_state = line_share_pkg::ST_IDLE;
        end
      end
      default: nxt_state = line_share_pkg::ST_IDLE;
    endcase
  end

  logic granted;
  assign granted = (state_ff != line_share_pkg::ST_IDLE);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= line_share_pkg::ST_IDLE;
      act_ff   <= '0;
      last_ff  <= PW'(PORTS - 1);
      dly_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == line_share_pkg::ST_IDLE && pick_any) begin
        act_ff <= pick_idx;
      end
      if (granted && nxt_state == line_share_pkg::ST_IDLE) begin
        last_ff <= act_ff;
      end
      if (state_ff != line_share_pkg::ST_DELAY) begin
        dly_ff <= '0;
      end else if (ms_tick) begin
        dly_ff <= dly_ff + 16'h1;
      end
    end
  end

  // ==========================================================================
  // inactivity cutoff
  // ==========================================================================
  logic [1:0]  sel_iv;
  logic        sel_src;
  logic [15:0] limit_ms;
  logic [15:0] idle_ms_ff;
  logic        tx_prev_ff;
  logic        rx_prev_ff;
  logic        tx_act;
  logic        rx_act;
  logic        activity;
  logic        timing;

  assign sel_iv   = port_cutoff_interval_selects[2*act_ff +: 2];
  assign sel_src  = port_activity_source_selects[act_ff];
  assign limit_ms = (sel_iv == line_share_pkg::CUTOFF_32S) ? 16'(LONG_MS) : 16'(SHORT_MS);
  assign tx_act   = (slave_txd[act_ff] != tx_prev_ff);
  assign rx_act   = (mst_q.rxd != rx_prev_ff);
  assign activity = tx_act || ((sel_src == line_share_pkg::ACT_TX_RX) && rx_act);
  assign timing   = granted && act_req && (sel_iv != line_share_pkg::CUTOFF_NONE) &&
                    (sel_iv != 2'h3);
  assign cutoff_hit = timing && !activity && ms_tick && (idle_ms_ff >= limit_ms - 16'h1);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      idle_ms_ff <= '0;
      tx_prev_ff <= line_share_pkg::MARK_LEVEL;
      rx_prev_ff <= line_share_pkg::MARK_LEVEL;
    end else begin
      tx_prev_ff <= slave_txd[act_ff];
      rx_prev_ff <= mst_q.rxd;
      if (!timing || activity || cutoff_hit) begin
        idle_ms_ff <= '0;
      end else if (ms_tick) begin
        idle_ms_ff <= idle_ms_ff + 16'h1;
      end
    end
  end

  // lock set on cutoff, cleared on request low then high
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_ff     <= '0;
      rts_prev_ff <= '0;
    end else begin
      rts_prev_ff <= req_raw;
      for (int p = 0; p < PORTS; p++) begin
        if (cutoff_hit && act_ff == PW'(p)) begin
          lock_ff[p] <= 1'b1;
        end else if (req_raw[p] && !rts_prev_ff[p]) begin
          lock_ff[p] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // signal gating outputs
  // ==========================================================================
  logic [PORTS-1:0] act_onehot;
  logic [PORTS-1:0] nxt_rxd;
  logic [PORTS-1:0] nxt_cts;
  logic             full_grant;
  assign full_grant = (state_ff == line_share_pkg::ST_GRANT);
  assign act_onehot = granted ? (PORTS'(1) << act_ff) : '0;
  // broadcast; gated to requesting active port
  assign nxt_rxd = (receive_fanout_select == line_share_pkg::FANOUT_BCAST) ?
                   {PORTS{mst_q.rxd}} :
                   ((act_onehot & slave_rts) & {PORTS{mst_q.rxd}}) |
                   ~(act_onehot & slave_rts);
  assign nxt_cts = (full_grant && act_req && mst_q.cts) ? act_onehot : '0;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      slave_rxd    <= '1;
      slave_cts    <= '0;
      master_txd   <= line_share_pkg::MARK_LEVEL;
      master_rts   <= 1'b0;
      grant_onehot <= '0;
      cutoff_lock  <= '0;
    end else begin
      slave_rxd    <= nxt_rxd;
      slave_cts    <= nxt_cts;
      // txd from granted slave else mark
      master_txd   <= granted ? slave_txd[act_ff] : line_share_pkg::MARK_LEVEL;
      // request forwarded after delay, drop immediate
      master_rts   <= full_grant && act_req && !cutoff_hit;
      grant_onehot <= act_onehot;
      cutoff_lock  <= lock_ff;
    end
  end

  logic unused_ok;
  assign unused_ok = fifo_in_ready;
endmodule

// *** testbench/line_share_props.sv ***
// concurrent checks on the line share arbiter ports
`timescale 1ns/1ns
module line_share_props #(
  parameter int unsigned PORTS    = 4,
  parameter int unsigned MS_TICK  = 10,
  parameter int unsigned DELAY_MS = 25
) (
  input wire logic             ref_clk,
  input wire logic             arst_n,
  input wire logic             request_delay_select,
  input wire logic             receive_fanout_select,
  input wire logic [PORTS-1:0] port_detect_disable,
  input wire logic [PORTS-1:0] slave_rts,
  input wire logic [PORTS-1:0] slave_rxd,
  input wire logic [PORTS-1:0] slave_cts,
  input wire logic             master_txd,
  input wire logic             master_rts,
  input wire logic [PORTS-1:0] grant_onehot,
  input wire logic [PORTS-1:0] cutoff_lock
);
  localparam int LOW  = (DELAY_MS - 1) * MS_TICK;
  localparam int HIGH = (DELAY_MS + 1) * MS_TICK + 6;
  logic [31:0] wait_ff;
  logic [31:0] nxt_wait;
  // cycles spent granted while the forwarded request is still low
  assign nxt_wait = (|grant_onehot && !master_rts) ? wait_ff + 32'h1 : 32'h0;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) wait_ff <= 32'h0;
    else wait_ff <= nxt_wait;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  one_grant_a: assert property ($onehot0(grant_onehot))
    else $error("more than one port granted");
  rts_nodelay_a: assert property (
    !request_delay_select && $rose(|grant_onehot) &&
    |(grant_onehot & slave_rts & ~port_detect_disable) |=> master_rts)
    else $error("request not forwarded at once");
  rts_delay_a: assert property (
    $rose(master_rts) && request_delay_select |-> wait_ff >= LOW && wait_ff <= HIGH)
    else $error("delayed request out of window");
  bcast_rxd_a: assert property (
    !receive_fanout_select && !$past(receive_fanout_select) |->
    slave_rxd == '0 || slave_rxd == '1)
    else $error("broadcast outputs differ");
  gated_mark_a: assert property (
    receive_fanout_select && $past(receive_fanout_select, 2) &&
    $past(grant_onehot) == grant_onehot && $past(grant_onehot, 2) == grant_onehot |->
    &(slave_rxd | grant_onehot))
    else $error("idle port not marking");
  cts_granted_a: assert property ((slave_cts & ~grant_onehot & ~$past(grant_onehot)) == '0)
    else $error("clear to send on ungranted port");
  txd_idle_a: assert property (
    grant_onehot == '0 && $past(grant_onehot) == '0 |-> master_txd)
    else $error("master txd not marking");
  rts_needs_grant_a: assert property (
    master_rts |-> (grant_onehot | $past(grant_onehot) | $past(grant_onehot, 2)) != '0)
    else $error("master request without grant");
  lock_skip_a: assert property ((grant_onehot & ~$past(grant_onehot) & cutoff_lock) == '0)
    else $error("locked port granted");
  detect_off_a: assert property (
    (grant_onehot & ~$past(grant_onehot) & $past(port_detect_disable, 2)) == '0)
    else $error("disabled port granted");
endmodule
bind serial_line_share_arbiter line_share_props #(
  .PORTS(PORTS), .MS_TICK(MS_TICK), .DELAY_MS(DELAY_MS)
) props_i (
  .ref_clk(ref_clk), .arst_n(arst_n), .request_delay_select(request_delay_select),
  .receive_fanout_select(receive_fanout_select), .port_detect_disable(port_detect_disable),
  .slave_rts(slave_rts),
  .slave_rxd(slave_rxd), .slave_cts(slave_cts), .master_txd(master_txd),
  .master_rts(master_rts), .grant_onehot(grant_onehot), .cutoff_lock(cutoff_lock)
);

// *** testbench/master_modem_model.sv ***
// behavioural model of the modem on the master port
`timescale 1ns/1ns
module master_modem_model (
  input  wire logic                  ref_clk,
  input  wire logic                  arst_n,
  input  wire logic                  master_rts,
  input  wire logic                  rx_quiet,
  output line_share_pkg::master_in_t master_in
);
  logic [1:0] rts_pipe_ff;
  logic [3:0] bit_cnt_ff;
  logic       rxd_ff;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rts_pipe_ff <= 2'h0;
      bit_cnt_ff  <= 4'h0;
      rxd_ff      <= 1'h1;
    end else begin
      rts_pipe_ff <= {rts_pipe_ff[0], master_rts};
      bit_cnt_ff  <= bit_cnt_ff + 4'h1;
      // receive stream toggles every 16 cycles unless held quiet
      if (rx_quiet) rxd_ff <= 1'h1;
      else if (bit_cnt_ff == 4'hF) rxd_ff <= ~rxd_ff;
    end
  end
  // clear to send answers two cycles late and falls with the request
  assign master_in = {rxd_ff, rts_pipe_ff[1] & master_rts};
endmodule

// *** testbench/testbench.sv ***
// self-checking bench for the line share arbiter
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("Error %0t: got %h want %h", $time, g, e); end end
module testbench;
  logic                       ref_clk, arst_n, dly, fan, pol, quiet, m_txd, m_rts, r;
  logic [7:0]                 ivl;
  logic [3:0]                 act, dis, rts, txd, rxd, cts, grant, lock;
  line_share_pkg::master_in_t m_in;
  int                         bad_count, compares, n;
  serial_line_share_arbiter #(.PORTS(4), .MS_TICK(10), .DELAY_MS(3), .LONG_MS(8),
    .SHORT_MS(4)) uut (.ref_clk(ref_clk), .arst_n(arst_n),
    .request_delay_select(dly), .receive_fanout_select(fan), .selection_policy_select(pol),
    .port_cutoff_interval_selects(ivl), .port_activity_source_selects(act),
    .port_detect_disable(dis), .slave_rts(rts), .slave_txd(txd), .slave_rxd(rxd),
    .slave_cts(cts), .master_in(m_in), .master_txd(m_txd), .master_rts(m_rts),
    .grant_onehot(grant), .cutoff_lock(lock));
  master_modem_model modem (.ref_clk(ref_clk), .arst_n(arst_n), .master_rts(m_rts),
    .rx_quiet(quiet), .master_in(m_in));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic wait_grant(input logic [3:0] exp);
    for (n = 0; n < 200 && grant !== exp; n++) tick(1);
  endtask
  // slaves release the line between transfers
  task automatic release_all();
    rts = 4'h0;
    tick(6);
  endtask
  task automatic t_priority();
    pol = 1'h1; dis = 4'h4; rts = 4'hE;
    wait_grant(4'h2); `CHK(grant, 4'h2)
    tick(20); `CHK(grant, 4'h2)
    rts = 4'hC; wait_grant(4'h8); `CHK(grant, 4'h8)
    release_all(); dis = 4'h0; `CHK(m_rts, 1'h0)
    $display("priority test done");
  endtask
  task automatic t_round_robin();
    pol = 1'h0; rts = 4'hF;
    wait_grant(4'h1); `CHK(grant, 4'h1)
    rts = 4'hE; wait_grant(4'h2); `CHK(grant, 4'h2)
    rts = 4'hF; tick(2); rts = 4'hD;
    wait_grant(4'h4); `CHK(grant, 4'h4)
    release_all();
    $display("round robin test done");
  endtask
  task automatic rxd_settle();
    r = m_in.rxd;
    for (n = 0; n < 40 && m_in.rxd === r; n++) tick(1);
    tick(5);
  endtask
  task automatic t_fanout();
    fan = 1'h1; rts = 4'h4; wait_grant(4'h4); tick(10);
    `CHK(cts, 4'h4)
    rxd_settle(); `CHK(rxd, {1'h1, m_in.rxd, 2'h3})
    txd = 4'hB; tick(3); `CHK(m_txd, 1'h0)
    txd = 4'hF; fan = 1'h0;
    rxd_settle(); `CHK(rxd, {4{m_in.rxd}})
    release_all(); `CHK(cts, 4'h0)
    `CHK(m_txd, 1'h1)
    $display("fanout test done");
  endtask
  task automatic t_delay();
    dly = 1'h1; rts = 4'h1;
    for (n = 0; n < 100 && m_rts !== 1'h1; n++) tick(1);
    `CHK(n >= 20 && n <= 50, 1'b1)
    rts = 4'h0; tick(3); `CHK(m_rts, 1'h0)
    tick(3); dly = 1'h0; rts = 4'h2;
    for (n = 0; n < 100 && m_rts !== 1'h1; n++) tick(1);
    `CHK(n <= 4, 1'b1)
    release_all();
    $display("delay test done");
  endtask
  task automatic t_cutoff();
    ivl = 8'h39; act = 4'h8; rts = 4'h1; wait_grant(4'h1);
    repeat (10) begin
      tick(20);
      txd[0] = ~txd[0];
    end
    `CHK({lock[0], grant}, 5'h01)
    for (n = 0; n < 200 && lock[0] !== 1'h1; n++) tick(1);
    `CHK(n >= 30 && n <= 60, 1'b1)
    tick(20); `CHK(grant, 4'h0)
    rts = 4'h0; tick(3); rts = 4'h1;
    wait_grant(4'h1); `CHK(grant, 4'h1)
    rts = 4'h0; tick(6); rts = 4'h2; tick(150);
    `CHK({lock[1], grant}, 5'h02)
    rts = 4'h0; tick(6); rts = 4'h4; tick(150);
    `CHK({lock[2], grant}, 5'h04)
    rts = 4'h0; tick(6); rts = 4'h8; tick(200);
    `CHK(lock[3], 1'h0)
    // go quiet right after a receive edge so the last activity is known
    r = m_in.rxd;
    for (n = 0; n < 40 && m_in.rxd === r; n++) tick(1);
    quiet = 1'h1;
    for (n = 0; n < 300 && lock[3] !== 1'h1; n++) tick(1);
    `CHK(n >= 70 && n <= 100, 1'b1)
    release_all();
    $display("cutoff test done");
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    arst_n = 1'b0; dly = 1'h0; fan = 1'h0; pol = 1'h0; quiet = 1'h0;
    ivl = 8'hAA; act = 4'hF; dis = 4'h0; rts = 4'h0; txd = 4'hF;
    bad_count = 0; compares = 0;
    repeat (8) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    tick(2);
    t_priority();
    t_round_robin();
    t_fanout();
    t_delay();
    t_cutoff();
    tally_and_finish();
  end
endmodule
